// ==== logic/cer_pkg.sv ====
// Purpose: shared constants and carriers for the configurable embedded RAM
// Assumes: AHB-Lite register access, one clock
// Notes: block size chosen by a top-level parameter
package cer_pkg;

   localparam int SIZE_SMALL = 0;
   localparam int SIZE_MID = 1;
   localparam int SIZE_LARGE = 2;

   localparam int BYTE_W = 9;
   localparam int SHIFT_MAX = 4;
   localparam int COLL_W = 8;

   localparam logic [31:0] CFG_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam logic [31:0] CFG_RST = 32'h0000_0001;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [2:0] {
      CER_TDP = 3'h0,
      CER_SDP = 3'h1,
      CER_SP = 3'h2,
      CER_ROM = 3'h3,
      CER_FIFO = 3'h4,
      CER_DUALSP = 3'h5
   } cer_mode_t;

   function automatic int cer_depth(input int s);
      return (s == SIZE_SMALL) ? 32 : (s == SIZE_MID) ? 128 : 4096;
   endfunction : cer_depth

   function automatic int cer_width(input int s);
      return (s == SIZE_SMALL) ? 18 : (s == SIZE_MID) ? 36 : 144;
   endfunction : cer_width

   typedef struct packed {
      logic [16:0] rsvd;
      logic [2:0] shiftB;
      logic pad1;
      logic [2:0] shiftA;
      logic pad0;
      logic flowThru;
      logic rdwOld;
      logic outRegB;
      logic outRegA;
      logic [2:0] mode;
   } cer_cfg_t;

   typedef struct packed {
      logic [14:0] rsvd;
      logic flowAct;
      logic [COLL_W-1:0] collCnt;
      logic downgraded;
      logic beAvail;
      logic tdpAvail;
      logic [2:0] mode;
      logic [1:0] size;
   } cer_stat_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } cer_ahb_req_t;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } cer_ahb_rsp_t;

endpackage : cer_pkg

// ==== logic/cer_clr_reg.sv ====
// Purpose: register stage with asynchronous clear and load enable
// Assumes: clr is the OR of reset and any block clear
// Notes: used for input and output registers of each port
`timescale 1ns/1ps
module cer_clr_reg #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] state_d;

   always_comb begin
      state_d = en ? d : q;
   end

   always_ff @(posedge mclk or posedge clr) begin
      if (clr) begin
         q <= '0;
      end else begin
         q <= state_d;
      end
   end

endmodule : cer_clr_reg

// ==== logic/cer_ram_top.sv ====
// Purpose: configurable embedded RAM block, small, mid or large size
// Assumes: user ports synchronous to mclk; port rates set by clock enables
// Notes: mode, widths and output registers are set over AHB-Lite
//
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// R1 - Mid and large sizes allow two reads, writes or mixed, ports at own rates.
// R2 - Small size never runs true dual-port; request falls back to simple dual-port.
// R3 - Simple dual-port reads during a write return old data or undefined bits.
// R4 - Single-port: no read with write; written word shown after commit.
// R5 - Each port of a dual-port mode may use its own data width.
// R6 - All inputs registered; internal write strobe generated from the clock. Code registers write inputs only; read address and enables are not.
// R7 - Output registers optional; bypass removes one pipeline stage.
// R8 - Small and mid simple dual-port support flow-through reads, outputs bypassed.
// R9 - Mid block can hold two single-port memories, each in half.
// R10 - Small and mid clear input and output registers; large only output.
// R11 - Large has no preload; ROM use needs user load then writes held off.
// R12 - Narrow memories run blocks side by side, no control in data path.
// R13 - Input clear acts at once, seen at output next edge; output clear immediate.
// R14 - Mid and large have byte enables masking bytes during a write. Code applies them only at full port width (shift 0).
// R15 - Small and mid outputs cleared at power-up; large may be arbitrary.
module cer_ram_top #(
   parameter int SIZE_SEL = cer_pkg::SIZE_MID
) (
   input wire logic mclk,
   input wire logic rst,
   input wire cer_pkg::cer_ahb_req_t ahbReq,
   output cer_pkg::cer_ahb_rsp_t ahbRsp,
   input wire logic inClr,
   input wire logic outClr,
   input wire logic ceA,
   input wire logic weA,
   input wire logic reA,
   input wire logic [cer_pkg::cer_width(SIZE_SEL)/cer_pkg::BYTE_W-1:0] beA,
   input wire logic [$clog2(cer_pkg::cer_depth(SIZE_SEL))+cer_pkg::SHIFT_MAX-1:0] addrA,
   input wire logic [cer_pkg::cer_width(SIZE_SEL)-1:0] dataA,
   output logic [cer_pkg::cer_width(SIZE_SEL)-1:0] qA,
   input wire logic ceB,
   input wire logic weB,
   input wire logic reB,
   input wire logic [cer_pkg::cer_width(SIZE_SEL)/cer_pkg::BYTE_W-1:0] beB,
   input wire logic [$clog2(cer_pkg::cer_depth(SIZE_SEL))+cer_pkg::SHIFT_MAX-1:0] addrB,
   input wire logic [cer_pkg::cer_width(SIZE_SEL)-1:0] dataB,
   output logic [cer_pkg::cer_width(SIZE_SEL)-1:0] qB
);

   localparam int DW = cer_pkg::cer_width(SIZE_SEL);
   localparam int DEPTH = cer_pkg::cer_depth(SIZE_SEL);
   localparam int WAW = $clog2(DEPTH);
   localparam int AW = WAW + cer_pkg::SHIFT_MAX;
   localparam int BEW = DW / cer_pkg::BYTE_W;
   localparam int IW = 1 + BEW + AW + DW;
   localparam logic [2:0] SH_MAX = 3'(cer_pkg::SHIFT_MAX);
   localparam bit IS_SMALL = (SIZE_SEL == cer_pkg::SIZE_SMALL);
   localparam bit IS_MID = (SIZE_SEL == cer_pkg::SIZE_MID);
   localparam bit IS_LARGE = (SIZE_SEL == cer_pkg::SIZE_LARGE);

   typedef struct packed {
      cer_pkg::cer_cfg_t cfg;
      logic [cer_pkg::COLL_W-1:0] coll;
      logic dWrite;
      logic dCfg;
      logic [31:0] rdata;
      logic [1:0][DW-1:0] qArr;
   } cer_state_t;

   // R15 cleared power-up
   localparam cer_state_t ST_RST = '{
      cfg: cer_pkg::cer_cfg_t'(cer_pkg::CFG_RST),
      rdata: cer_pkg::RDATA_RST,
      default: '0
   };

   cer_state_t state_d;
   cer_state_t state_q;
   logic [DW-1:0] mem [DEPTH];

   logic [1:0] pCe;
   logic [1:0] pWe;
   logic [1:0] pRe;
   logic [BEW-1:0] pBe [2];
   logic [AW-1:0] pAddr [2];
   logic [DW-1:0] pData [2];

   logic [IW-1:0] inQ [2];
   logic [1:0] cWe;
   logic [BEW-1:0] cBe [2];
   logic [AW-1:0] cAddr [2];
   logic [DW-1:0] cDat [2];
   logic [WAW-1:0] cIdx [2];
   logic [WAW-1:0] rIdx [2];
   logic [DW-1:0] oldWord [2];
   logic [DW-1:0] wrWord [2];
   logic [DW-1:0] rdVal [2];
   logic [DW-1:0] outQ [2];
   logic [DW-1:0] qOut [2];
   logic [2:0] sh [2];
   logic [1:0] collide;
   logic [1:0] rdReq;
   logic [1:0] wrAllow;
   logic [1:0] rdAllow;
   logic [1:0] outRegEff;

   cer_pkg::cer_cfg_t cfg;
   cer_pkg::cer_cfg_t cfgNew;
   cer_pkg::cer_stat_t stat;
   cer_pkg::cer_mode_t modeEff;
   logic downgr;
   logic sdpLike;
   logic spLike;
   logic dualSp;
   logic flowOn;
   logic inClrEff;
   logic addrOk;
   logic isCfg;
   logic isStat;
   logic cfgWr;

   function automatic logic [DW-1:0] lowMask(input logic [2:0] s);
      int nw;
      nw = DW >> s;
      return {DW{1'b1}} >> (DW - nw);
   endfunction : lowMask

   function automatic int laneOff(input logic [AW-1:0] a, input logic [2:0] s);
      return (int'(a) % (1 << s)) * (DW >> s);
   endfunction : laneOff

   function automatic logic [DW-1:0] extract(input logic [DW-1:0] w, input logic [AW-1:0] a,
                                             input logic [2:0] s);
      return (w >> laneOff(a, s)) & lowMask(s);
   endfunction : extract

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] dat,
                                           input logic [AW-1:0] a, input logic [2:0] s,
                                           input logic [BEW-1:0] be);
      logic [DW-1:0] m;
      logic [DW-1:0] d;
      m = lowMask(s) << laneOff(a, s);
      d = (dat & lowMask(s)) << laneOff(a, s);
      if (s == 3'h0) begin
         for (int b = 0; b < BEW; b++) begin
            if (!be[b]) begin
               m[b*cer_pkg::BYTE_W +: cer_pkg::BYTE_W] = '0;
            end
         end
      end
      return (old & ~m) | (d & m);
   endfunction : merge

   assign pCe = {ceB, ceA};
   assign pWe = {weB, weA};
   assign pRe = {reB, reA};
   assign pBe[0] = beA;
   assign pBe[1] = beB;
   assign pAddr[0] = addrA;
   assign pAddr[1] = addrB;
   assign pData[0] = dataA;
   assign pData[1] = dataB;
   assign cfg = state_q.cfg;

   always_comb begin
      downgr = 1'b0;
      modeEff = cer_pkg::CER_SDP;
      unique case (cfg.mode)
         cer_pkg::CER_TDP: begin
            // R2 no small dual
            if (IS_SMALL) begin
               downgr = 1'b1;
            end else begin
               modeEff = cer_pkg::CER_TDP;
            end
         end
         cer_pkg::CER_SDP: modeEff = cer_pkg::CER_SDP;
         cer_pkg::CER_SP: modeEff = cer_pkg::CER_SP;
         cer_pkg::CER_ROM: modeEff = cer_pkg::CER_ROM;
         cer_pkg::CER_FIFO: modeEff = cer_pkg::CER_FIFO;
         cer_pkg::CER_DUALSP: begin
            // R9 split only mid
            modeEff = IS_MID ? cer_pkg::CER_DUALSP : cer_pkg::CER_SP;
            downgr = !IS_MID;
         end
         default: downgr = 1'b1;
      endcase
   end

   assign sdpLike = (modeEff == cer_pkg::CER_SDP) || (modeEff == cer_pkg::CER_FIFO);
   assign dualSp = (modeEff == cer_pkg::CER_DUALSP);
   assign spLike = (modeEff == cer_pkg::CER_SP) || (modeEff == cer_pkg::CER_ROM) || dualSp;
   // R8 flow-through read
   assign flowOn = cfg.flowThru && sdpLike && !IS_LARGE;
   // R11 ROM writes blocked, small and mid only
   assign wrAllow[0] = !((modeEff == cer_pkg::CER_ROM) && !IS_LARGE);
   // R1 both ports active
   assign wrAllow[1] = (modeEff == cer_pkg::CER_TDP) || dualSp;
   assign rdAllow[0] = !sdpLike;
   assign rdAllow[1] = (modeEff == cer_pkg::CER_TDP) || sdpLike || dualSp;
   // R10 large keeps inputs
   assign inClrEff = inClr && !IS_LARGE;
   // R5 per-port width
   assign sh[0] = (cfg.shiftA > SH_MAX) ? SH_MAX : cfg.shiftA;
   assign sh[1] = (cfg.shiftB > SH_MAX) ? SH_MAX : cfg.shiftB;
   assign outRegEff = {cfg.outRegB && !flowOn, cfg.outRegA};

   generate
      for (genvar i = 0; i < 2; i++) begin : g_port
         // R6 registered inputs
         cer_clr_reg #(.W(IW)) u_in (
            .mclk(mclk),
            .clr(rst | inClrEff),
            .en(1'b1),
            .d({pWe[i] & pCe[i] & wrAllow[i], pBe[i], pAddr[i], pData[i]}),
            .q(inQ[i])
         );
         assign cWe[i] = inQ[i][IW-1];
         assign cBe[i] = IS_SMALL ? {BEW{1'b1}} : inQ[i][IW-2 -: BEW];
         assign cAddr[i] = inQ[i][AW+DW-1 -: AW];
         assign cDat[i] = inQ[i][DW-1:0];
         // R9 half per memory
         assign cIdx[i] = dualSp ? {1'(i), (WAW-1)'(cAddr[i] >> sh[i])} : WAW'(cAddr[i] >> sh[i]);
         assign rIdx[i] = dualSp ? {1'(i), (WAW-1)'(pAddr[i] >> sh[i])} : WAW'(pAddr[i] >> sh[i]);
         assign oldWord[i] = mem[cIdx[i]];
         // R14 byte lane mask
         assign wrWord[i] = merge(oldWord[i], cDat[i], cAddr[i], sh[i], cBe[i]);
         // R12 plain read path
         assign rdVal[i] = extract(mem[rIdx[i]], pAddr[i], sh[i]);
         assign rdReq[i] = pCe[i] && pRe[i] && rdAllow[i];
         assign collide[i] = (cWe[0] && (cIdx[0] == rIdx[i])) || (cWe[1] && (cIdx[1] == rIdx[i]));
         // R13 output clear immediate
         cer_clr_reg #(.W(DW)) u_out (
            .mclk(mclk),
            .clr(rst | outClr),
            .en(pCe[i]),
            .d(state_q.qArr[i]),
            .q(outQ[i])
         );
         // R7 optional output stage
         assign qOut[i] = (i == 1 && flowOn) ? rdVal[i] : outRegEff[i] ? outQ[i] : state_q.qArr[i];
      end
   endgenerate

   assign qA = qOut[0];
   assign qB = qOut[1];

   // R6 self-timed write strobe
   always_ff @(posedge mclk) begin
      for (int i = 1; i >= 0; i--) begin
         if (cWe[i]) begin
            mem[cIdx[i]] <= wrWord[i];
         end
      end
   end

   assign addrOk = ahbReq.hsel && ahbReq.hready && ahbReq.htrans[1];
   assign isCfg = ({ahbReq.haddr[31:2], 2'b00} == cer_pkg::CFG_OFS);
   assign isStat = ({ahbReq.haddr[31:2], 2'b00} == cer_pkg::STAT_OFS);
   assign cfgWr = state_q.dWrite && state_q.dCfg;

   always_comb begin
      cfgNew = cer_pkg::cer_cfg_t'(ahbReq.hwdata);
      cfgNew.rsvd = '0;
      cfgNew.pad0 = 1'b0;
      cfgNew.pad1 = 1'b0;
   end

   always_comb begin
      stat = '0;
      stat.size = 2'(SIZE_SEL);
      stat.mode = modeEff;
      stat.tdpAvail = !IS_SMALL;
      stat.beAvail = !IS_SMALL;
      stat.downgraded = downgr;
      stat.collCnt = state_q.coll;
      stat.flowAct = flowOn;
   end

   always_comb begin
      state_d = state_q;
      if (cfgWr) begin
         state_d.cfg = cfgNew;
      end
      state_d.dWrite = addrOk && ahbReq.hwrite;
      state_d.dCfg = addrOk && isCfg;
      if (addrOk && !ahbReq.hwrite) begin
         state_d.rdata = isCfg ? 32'(state_d.cfg) : isStat ? 32'(stat) : '0;
      end
      for (int i = 0; i < 2; i++) begin
         if (spLike && cWe[i]) begin
            // R4 write shown after commit
            state_d.qArr[i] = extract(wrWord[i], cAddr[i], sh[i]);
         end else if (rdReq[i]) begin
            // R3 read during write
            if (collide[i] && (IS_LARGE || !cfg.rdwOld)) begin
               state_d.qArr[i] = '1;
            end else begin
               state_d.qArr[i] = rdVal[i];
            end
            if (collide[i] && (state_q.coll != '1)) begin
               state_d.coll = state_q.coll + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign ahbRsp.hreadyout = 1'b1;
   assign ahbRsp.hresp = cer_pkg::HRESP_OKAY;
   assign ahbRsp.hrdata = state_q.rdata;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_tdp_dual_read;
      (modeEff == cer_pkg::CER_TDP) && rdReq[0] && rdReq[1] && !spLike && !collide[0] && !collide[1]
         |=> state_q.qArr[0] == $past(rdVal[0]) && state_q.qArr[1] == $past(rdVal[1]);
   endproperty
   a_tdp_dual_read: assert property (p_tdp_dual_read) else $error("dual read lost"); // R1

   property p_no_small_tdp;
      (cfg.mode == cer_pkg::CER_TDP) |-> (IS_SMALL ? modeEff == cer_pkg::CER_SDP && downgr
                                                     : modeEff == cer_pkg::CER_TDP);
   endproperty
   a_no_small_tdp: assert property (p_no_small_tdp) else $error("small block ran dual port"); // R2

   property p_sdp_rdw;
      sdpLike && rdReq[1] && collide[1]
         |=> state_q.qArr[1] == (IS_LARGE || !$past(cfg.rdwOld) ? {DW{1'b1}} : $past(rdVal[1]));
   endproperty
   a_sdp_rdw: assert property (p_sdp_rdw) else $error("bad read during write"); // R3

   property p_sp_show;
      spLike && cWe[0] |=> state_q.qArr[0] == extract($past(wrWord[0]), $past(cAddr[0]), $past(sh[0]));
   endproperty
   a_sp_show: assert property (p_sp_show) else $error("written word not shown"); // R4

   property p_width_read;
      rdReq[1] && !collide[1] && !spLike |=> state_q.qArr[1] == $past(rdVal[1]);
   endproperty
   a_width_read: assert property (p_width_read) else $error("narrow read wrong"); // R5

   sequence s_capture;
      pCe[0] && pWe[0] && wrAllow[0] && !inClrEff;
   endsequence
   sequence s_commit;
      (cWe[0] || inClrEff) ##1 (!cWe[0] || ($past(pCe[0]) && $past(pWe[0])));
   endsequence
   property p_strobe;
      s_capture |=> s_commit;
   endproperty
   a_strobe: assert property (p_strobe) else $error("write strobe not one cycle"); // R6

   property p_outreg;
      cfg.outRegA && pCe[0] && !outClr ##1 cfg.outRegA && !outClr |-> qA == $past(state_q.qArr[0]);
   endproperty
   a_outreg: assert property (p_outreg) else $error("output stage wrong"); // R7

   property p_flow;
      flowOn |-> !IS_LARGE && sdpLike && qB == rdVal[1];
   endproperty
   a_flow: assert property (p_flow) else $error("flow-through wrong"); // R8

   property p_split;
      dualSp && cWe[1] |-> cIdx[1][WAW-1] && (!cWe[0] || !cIdx[0][WAW-1]);
   endproperty
   a_split: assert property (p_split) else $error("half memories overlap"); // R9

   property p_in_clear;
      inClrEff |-> !cWe[0] && !cWe[1];
   endproperty
   a_in_clear: assert property (p_in_clear) else $error("input clear ignored"); // R13

   property p_out_clear;
      outClr && cfg.outRegA |-> qA == '0;
   endproperty
   a_out_clear: assert property (p_out_clear) else $error("output clear ignored"); // R10

   property p_rom;
      (modeEff == cer_pkg::CER_ROM) && !IS_LARGE |=> !cWe[0];
   endproperty
   a_rom: assert property (p_rom) else $error("ROM accepted a write"); // R11

   property p_byte_mask;
      cWe[0] && (sh[0] == 3'h0) && !cBe[0][0] |-> wrWord[0][8:0] == oldWord[0][8:0];
   endproperty
   a_byte_mask: assert property (p_byte_mask) else $error("masked byte changed"); // R14

endmodule : cer_ram_top

// ==== tb/cer_user_model.sv ====
// Purpose: user fabric logic model driving both RAM ports
// Assumes: mid size widths, both ports clocked by mclk
// Notes: clock enables held high; clears change by non-blocking assignment
`timescale 1ns/1ps
module cer_user_model (
   input wire logic mclk,
   output logic ceA,
   output logic weA,
   output logic reA,
   output logic [3:0] beA,
   output logic [10:0] addrA,
   output logic [35:0] dataA,
   output logic ceB,
   output logic weB,
   output logic reB,
   output logic [3:0] beB,
   output logic [10:0] addrB,
   output logic [35:0] dataB,
   output logic inClr,
   output logic outClr
);
   initial begin
      {ceA, ceB} = 2'h3;
      {weA, reA, weB, reB, inClr, outClr} = 6'h00;
      {beA, beB} = 8'hFF;
      {addrA, addrB} = 22'h0;
      {dataA, dataB} = 72'h0;
   end
   // Op bits are write A, read A, write B, read B
   task automatic cyc(input logic [3:0] op, input logic [10:0] aa, input logic [35:0] da,
         input logic [10:0] ab, input logic [35:0] db, input logic [3:0] be);
      @(posedge mclk);
      weA <= op[3];
      reA <= op[2] && !op[3];
      weB <= op[1];
      reB <= op[0];
      addrA <= aa;
      addrB <= ab;
      dataA <= da;
      dataB <= db;
      beA <= be;
      @(posedge mclk);
      {weA, reA, weB, reB} <= 4'h0;
      dataA <= ~da;
      dataB <= ~db;
   endtask : cyc
   // Port A write, then port B reads the same word as it commits
   task automatic wrRd(input logic [10:0] a, input logic [35:0] d);
      @(posedge mclk);
      weA <= 1'b1;
      addrA <= a;
      dataA <= d;
      beA <= 4'hF;
      @(posedge mclk);
      weA <= 1'b0;
      reB <= 1'b1;
      addrB <= a;
      @(posedge mclk);
      reB <= 1'b0;
   endtask : wrRd
   task automatic peekB(input logic [10:0] a);
      @(posedge mclk);
      addrB <= a;
      reB <= 1'b1;
      #5;
   endtask : peekB
   // Clear levels held across the next rising edge
   task automatic clr(input logic i, input logic o);
      inClr <= i;
      outClr <= o;
      @(posedge mclk);
   endtask : clr
endmodule : cer_user_model

// ==== tb/configurable_embedded_ram_test.sv ====
// Purpose: self-checking bench for the embedded RAM, mid size
// Assumes: zero-wait AHB-Lite slave, one clock
// Notes: each scenario is one task
`timescale 1ns/1ps
module configurable_embedded_ram_test;
   localparam logic [35:0] V5 = 36'h1_2345_6789;
   localparam logic [35:0] V6 = 36'hA_BCDE_F012;
   localparam logic [35:0] VA = 36'h3_1111_2222;
   localparam logic [35:0] VB = 36'h4_3333_4444;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic ceA, weA, reA, ceB, weB, reB, inClr, outClr;
   logic [3:0] beA, beB;
   logic [10:0] addrA, addrB;
   logic [35:0] dataA, dataB, qA, qB;
   cer_pkg::cer_ahb_req_t ahbReq;
   cer_pkg::cer_ahb_rsp_t ahbRsp;
   int errorCnt = 0;
   int checkCount = 0;
   assign ahbReq = {hsel, haddr, htrans, hwrite, 3'h2, ahbRsp.hreadyout, hwdata};
   always #25 mclk = ~mclk;
   cer_user_model u_usr (.mclk(mclk), .ceA(ceA), .weA(weA), .reA(reA), .beA(beA), .addrA(addrA),
      .dataA(dataA), .ceB(ceB), .weB(weB), .reB(reB), .beB(beB), .addrB(addrB), .dataB(dataB),
      .inClr(inClr), .outClr(outClr));
   cer_ram_top #(.SIZE_SEL(cer_pkg::SIZE_MID)) DUT (.mclk(mclk), .rst(rst), .ahbReq(ahbReq),
      .ahbRsp(ahbRsp), .inClr(inClr), .outClr(outClr), .ceA(ceA), .weA(weA), .reA(reA), .beA(beA),
      .addrA(addrA), .dataA(dataA), .qA(qA), .ceB(ceB), .weB(weB), .reB(reB), .beB(beB),
      .addrB(addrB), .dataB(dataB), .qB(qB));
   task automatic printVerdict();
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : printVerdict
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checkCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic waitRdy();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ahbRsp.hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         errorCnt++;
         $display("[FAIL] %0t bus timeout", $time);
         printVerdict();
      end
   endtask : waitRdy
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] rd);
      @(posedge mclk);
      haddr <= a;
      hwrite <= wr;
      htrans <= cer_pkg::HTRANS_NONSEQ;
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = ahbRsp.hrdata;
   endtask : ahb
   task automatic wcfg(input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, cer_pkg::CFG_OFS, d, x);
   endtask : wcfg
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      chk({4'h0, x}, {4'h0, exp});
   endtask : rchk
   task automatic tReset();
      chk(qA, 36'h0); // outputs cleared
      chk(qB, 36'h0); // outputs cleared
      chk({35'h0, ahbRsp.hresp}, 36'h0); // bus answer at reset
      rchk(cer_pkg::CFG_OFS, cer_pkg::CFG_RST); // default mode
      rchk(cer_pkg::STAT_OFS, 32'h0000_0065); // mid features
      rchk(32'h0000_0008, 32'h0);
   endtask : tReset
   task automatic tSingle();
      wcfg(32'h0000_0002);
      u_usr.cyc(4'h8, 11'h005, V5, 11'h000, 36'h0, 4'hF);
      @(posedge mclk);
      #1 chk(qA, V5); // shown after write
      u_usr.cyc(4'h8, 11'h006, V6, 11'h000, 36'h0, 4'hF);
      @(posedge mclk);
      #1 chk(qA, V6); // shown after write
      u_usr.cyc(4'h4, 11'h005, 36'h0, 11'h000, 36'h0, 4'hF);
      #1 chk(qA, V5); // bypass read
   endtask : tSingle
   task automatic tClear();
      u_usr.cyc(4'h8, 11'h005, 36'h0_0000_0BAD, 11'h000, 36'h0, 4'hF);
      u_usr.clr(1'b1, 1'b0);
      u_usr.clr(1'b0, 1'b0);
      u_usr.cyc(4'h4, 11'h005, 36'h0, 11'h000, 36'h0, 4'hF);
      #1 chk(qA, V5); // pending write cleared
   endtask : tClear
   task automatic tOutReg();
      wcfg(32'h0000_000A);
      u_usr.cyc(4'h4, 11'h006, 36'h0, 11'h000, 36'h0, 4'hF);
      #1 chk(qA, V5); // one more stage
      @(posedge mclk);
      #1 chk(qA, V6); // registered read
      u_usr.clr(1'b0, 1'b1);
      chk(qA, 36'h0); // output clear at once
      u_usr.clr(1'b0, 1'b0);
   endtask : tOutReg
   task automatic tBytes();
      wcfg(32'h0000_0000);
      u_usr.cyc(4'h8, 11'h007, 36'hF_FFFF_FFFF, 11'h000, 36'h0, 4'hF);
      u_usr.cyc(4'h8, 11'h007, 36'h0, 11'h000, 36'h0, 4'hA);
      u_usr.cyc(4'h4, 11'h007, 36'h0, 11'h000, 36'h0, 4'hF);
      #1 chk(qA, 36'h0_07FC_01FF); // masked bytes
   endtask : tBytes
   task automatic tDual();
      u_usr.cyc(4'hA, 11'h00A, VA, 11'h00B, VB, 4'hF);
      u_usr.cyc(4'h5, 11'h00B, 36'h0, 11'h00A, 36'h0, 4'hF);
      #1 chk(qA, VB); // both ports
      chk(qB, VA); // both ports
   endtask : tDual
   task automatic tMixed();
      wcfg(32'h0000_2000);
      u_usr.cyc(4'h2, 11'h000, 36'h0, 11'h02F, 36'h0_0000_01AB, 4'hF);
      u_usr.cyc(4'h5, 11'h00B, 36'h0, 11'h029, 36'h0, 4'hF);
      #1 chk(qA, {9'h1AB, VB[26:0]}); // narrow write
      chk({27'h0, qB[8:0]}, {27'h0, VA[17:9]}); // narrow read
   endtask : tMixed
   task automatic tSplit();
      wcfg(32'h0000_0005);
      u_usr.cyc(4'hA, 11'h003, VA, 11'h003, VB, 4'hF);
      u_usr.cyc(4'h5, 11'h003, 36'h0, 11'h003, 36'h0, 4'hF);
      #1 chk(qA, VA); // lower half
      chk(qB, VB); // upper half
      wcfg(32'h0000_0003);
      u_usr.cyc(4'h8, 11'h003, V5, 11'h000, 36'h0, 4'hF);
      u_usr.cyc(4'h4, 11'h003, 36'h0, 11'h000, 36'h0, 4'hF);
      #1 chk(qA, VA); // ROM write held off
   endtask : tSplit
   task automatic tCollide();
      wcfg(32'h0000_0021);
      u_usr.cyc(4'h8, 11'h00C, V5, 11'h000, 36'h0, 4'hF);
      u_usr.wrRd(11'h00C, V6);
      #1 chk(qB, V5); // old data
      wcfg(32'h0000_0001);
      u_usr.wrRd(11'h00C, VA);
      #1 chk(qB, 36'hF_FFFF_FFFF); // undefined bits
      rchk(cer_pkg::STAT_OFS, 32'h0000_0265); // collisions counted
   endtask : tCollide
   task automatic tFlow();
      wcfg(32'h0000_0041);
      u_usr.peekB(11'h00C);
      chk(qB, VA); // same cycle read
   endtask : tFlow
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      #1;
      tReset();
      tSingle();
      tClear();
      tOutReg();
      tBytes();
      tDual();
      tMixed();
      tSplit();
      tCollide();
      tFlow();
      printVerdict();
   end
endmodule : configurable_embedded_ram_test
